// >>> pkg/pmdb_pkg.sv
// package: register map and field layout of the module-disable bank
package pmdb_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] OFF_PRI_SEVEN  = 8'h00;
  localparam logic [7:0] OFF_PRI_EIGHT  = 8'h04;
  localparam logic [7:0] OFF_SEC_LOCK   = 8'h08;
  localparam logic [7:0] OFF_SEC_ONE    = 8'h0C;
  localparam logic [7:0] OFF_SEC_TWO    = 8'h10;
  localparam logic [7:0] OFF_SEC_FOUR   = 8'h14;
  localparam logic [7:0] OFF_SEC_SIX    = 8'h18;
  localparam logic [7:0] OFF_SEC_SEVEN  = 8'h1C;

  // implemented-bit masks; all other positions read zero
  localparam logic [15:0] MASK_PRI_SEVEN = 16'h0108;
  localparam logic [15:0] MASK_PRI_EIGHT = 16'h183E;
  localparam logic [15:0] MASK_SEC_LOCK  = 16'h0800;
  localparam logic [15:0] MASK_SEC_ONE   = 16'h0EA9;
  localparam logic [15:0] MASK_SEC_TWO   = 16'h000F;
  localparam logic [15:0] MASK_SEC_FOUR  = 16'h0008;
  localparam logic [15:0] MASK_SEC_SIX   = 16'h0300;
  localparam logic [15:0] MASK_SEC_SEVEN = 16'h0702;

  // every implemented field clears at reset
  localparam logic [15:0] REG_RESET      = 16'h0000;

  // field positions
  localparam int UNLOCK_BIT   = 11;
  localparam int P7_CMP1      = 8;
  localparam int P7_TRIG      = 3;
  localparam int P8_EDGE2     = 12;
  localparam int P8_EDGE1     = 11;
  localparam int P8_CELL_LO   = 2;
  localparam int P8_CURRENT   = 1;
  localparam int S1_TIMER1    = 11;
  localparam int S1_ENCODER   = 10;
  localparam int S1_PWM       = 9;
  localparam int S1_I2C1      = 7;
  localparam int S1_UART1     = 5;
  localparam int S1_SPI1      = 3;
  localparam int S1_ADC       = 0;
  localparam int S4_REFCLK    = 3;
  localparam int S6_DMA0      = 8;
  localparam int S7_CMP1      = 8;
  localparam int S7_GAIN      = 1;

  // per-module disable outputs
  typedef struct packed {
    logic       comparator1_off;
    logic       trigger_generator_off;
    logic       edge_serial2_off;
    logic       edge_serial1_off;
    logic [3:0] logic_cell_off;
    logic       current_source_off;
  } pmdb_pri_off_s;

  typedef struct packed {
    logic       timer1_off;
    logic       encoder_off;
    logic       pwm_off;
    logic       i2c1_off;
    logic       uart1_off;
    logic       spi1_off;
    logic       adc_off;
    logic [3:0] capcomp_off;
    logic       refclk_out_off;
    logic [1:0] dma_chan_off;
    logic [2:0] comparator_off;
    logic       gain_amp_off;
  } pmdb_sec_off_s;

endpackage

// >>> hw/pmdb_bank.sv
// design: apb register bank driving per-module disable outputs
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - secondary disable bits take writes only while the unlock bit is 1.
// - every implemented field clears to zero at reset.
// - unimplemented bits read zero and ignore writes.
// - a disable field set to 1 turns its module off, 0 leaves it on.
// - primary seven holds comparator 1 at bit 8, trigger gen at bit 3.
// - primary eight holds edge serial 2 and 1 at bits 12 and 11.
// - primary eight holds logic cells 4..1 at bits 5 down to 2.
// - primary eight holds current source at bit 1, rest unimplemented.
// - the eighth register with those fields exists only for primary.
// - secondary one holds timer 1, encoder, pwm at bits 11, 10, 9.
// - secondary one holds i2c1 bit 7, uart1 bit 5, spi1 bit 3, adc 0.
// - secondary two holds capture/compare 4..1 at bits 3 down to 0.
// - secondary four holds reference clock output off at bit 3.
// - secondary six holds dma channel 1 at bit 9 and channel 0 at bit 8.
// - secondary seven holds comparators 3, 2, 1 at bits 10, 9, 8.
// - secondary seven holds gain amplifier at bit 1, rest unimplemented.
module pmdb_bank (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  output pmdb_pkg::pmdb_pri_off_s      pri_off,
  output pmdb_pkg::pmdb_sec_off_s      sec_off
);

  logic [15:0] primary_disable_seven;
  logic [15:0] primary_disable_eight;
  logic [15:0] secondary_disable_lock;
  logic [15:0] secondary_disable_one;
  logic [15:0] secondary_disable_two;
  logic [15:0] secondary_disable_four;
  logic [15:0] secondary_disable_six;
  logic [15:0] secondary_disable_seven;
  logic        disable_write_unlock;
  logic        setup;
  logic        wr_go;
  logic        hit;
  logic [15:0] wdata;
  logic [15:0] next_rdata;

  // setup phase decode; answer comes one cycle later in the access phase
  assign setup = psel & ~penable;
  assign wr_go = psel & penable & pwrite & pready;
  assign disable_write_unlock =
    secondary_disable_lock[pmdb_pkg::UNLOCK_BIT];

  // byte strobes merged into the low halfword; a dead lane writes zeros
  always_comb begin
    wdata = {pstrb[1] ? pwdata[15:8] : 8'h00,
             pstrb[0] ? pwdata[7:0]  : 8'h00};
  end

  // pready raised for exactly one access-phase cycle (one wait-free answer)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  // address decode for mapped offsets
  always_comb begin
    case (paddr)
      pmdb_pkg::OFF_PRI_SEVEN,
      pmdb_pkg::OFF_PRI_EIGHT,
      pmdb_pkg::OFF_SEC_LOCK,
      pmdb_pkg::OFF_SEC_ONE,
      pmdb_pkg::OFF_SEC_TWO,
      pmdb_pkg::OFF_SEC_FOUR,
      pmdb_pkg::OFF_SEC_SIX,
      pmdb_pkg::OFF_SEC_SEVEN: hit = 1'b1;
      default:                 hit = 1'b0;
    endcase
  end

  // read mux; masks keep unimplemented bits at zero
  always_comb begin
    case (paddr)
      pmdb_pkg::OFF_PRI_SEVEN: next_rdata = primary_disable_seven;
      pmdb_pkg::OFF_PRI_EIGHT: next_rdata = primary_disable_eight;
      pmdb_pkg::OFF_SEC_LOCK:  next_rdata = secondary_disable_lock;
      pmdb_pkg::OFF_SEC_ONE:   next_rdata = secondary_disable_one;
      pmdb_pkg::OFF_SEC_TWO:   next_rdata = secondary_disable_two;
      pmdb_pkg::OFF_SEC_FOUR:  next_rdata = secondary_disable_four;
      pmdb_pkg::OFF_SEC_SIX:   next_rdata = secondary_disable_six;
      pmdb_pkg::OFF_SEC_SEVEN: next_rdata = secondary_disable_seven;
      default:                 next_rdata = 16'h0000;
    endcase
  end

  // read data and error registered at setup so they stand in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : {16'h0000, next_rdata};
      pslverr <= ~hit;
    end else if (pready) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // primary registers: no lock in this bank, writes always land
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_disable_seven <= pmdb_pkg::REG_RESET;
      primary_disable_eight <= pmdb_pkg::REG_RESET;
    end else if (wr_go) begin
      if (paddr == pmdb_pkg::OFF_PRI_SEVEN)
        primary_disable_seven <= wdata & pmdb_pkg::MASK_PRI_SEVEN;
      if (paddr == pmdb_pkg::OFF_PRI_EIGHT)
        primary_disable_eight <= wdata & pmdb_pkg::MASK_PRI_EIGHT;
    end
  end

  // unlock register itself is always writable, else it could never open
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      secondary_disable_lock <= pmdb_pkg::REG_RESET;
    end else if (wr_go && paddr == pmdb_pkg::OFF_SEC_LOCK) begin
      secondary_disable_lock <= wdata & pmdb_pkg::MASK_SEC_LOCK;
    end
  end

  // secondary disables: writes dropped silently while locked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      secondary_disable_one   <= pmdb_pkg::REG_RESET;
      secondary_disable_two   <= pmdb_pkg::REG_RESET;
      secondary_disable_four  <= pmdb_pkg::REG_RESET;
      secondary_disable_six   <= pmdb_pkg::REG_RESET;
      secondary_disable_seven <= pmdb_pkg::REG_RESET;
    end else if (wr_go && disable_write_unlock) begin
      case (paddr)
        pmdb_pkg::OFF_SEC_ONE:
          secondary_disable_one <= wdata & pmdb_pkg::MASK_SEC_ONE;
        pmdb_pkg::OFF_SEC_TWO:
          secondary_disable_two <= wdata & pmdb_pkg::MASK_SEC_TWO;
        pmdb_pkg::OFF_SEC_FOUR:
          secondary_disable_four <= wdata & pmdb_pkg::MASK_SEC_FOUR;
        pmdb_pkg::OFF_SEC_SIX:
          secondary_disable_six <= wdata & pmdb_pkg::MASK_SEC_SIX;
        pmdb_pkg::OFF_SEC_SEVEN:
          secondary_disable_seven <= wdata & pmdb_pkg::MASK_SEC_SEVEN;
        default: ;
      endcase
    end
  end

  // disable outputs: registered copy, one cycle behind the stored field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pri_off <= '0;
      sec_off <= '0;
    end else begin
      pri_off.comparator1_off <=
        primary_disable_seven[pmdb_pkg::P7_CMP1];
      pri_off.trigger_generator_off <=
        primary_disable_seven[pmdb_pkg::P7_TRIG];
      pri_off.edge_serial2_off <=
        primary_disable_eight[pmdb_pkg::P8_EDGE2];
      pri_off.edge_serial1_off <=
        primary_disable_eight[pmdb_pkg::P8_EDGE1];
      pri_off.logic_cell_off <=
        primary_disable_eight[pmdb_pkg::P8_CELL_LO +: 4];
      pri_off.current_source_off <=
        primary_disable_eight[pmdb_pkg::P8_CURRENT];
      sec_off.timer1_off  <= secondary_disable_one[pmdb_pkg::S1_TIMER1];
      sec_off.encoder_off <= secondary_disable_one[pmdb_pkg::S1_ENCODER];
      sec_off.pwm_off     <= secondary_disable_one[pmdb_pkg::S1_PWM];
      sec_off.i2c1_off    <= secondary_disable_one[pmdb_pkg::S1_I2C1];
      sec_off.uart1_off   <= secondary_disable_one[pmdb_pkg::S1_UART1];
      sec_off.spi1_off    <= secondary_disable_one[pmdb_pkg::S1_SPI1];
      sec_off.adc_off     <= secondary_disable_one[pmdb_pkg::S1_ADC];
      sec_off.capcomp_off <= secondary_disable_two[3:0];
      sec_off.refclk_out_off <=
        secondary_disable_four[pmdb_pkg::S4_REFCLK];
      sec_off.dma_chan_off <=
        secondary_disable_six[pmdb_pkg::S6_DMA0 +: 2];
      sec_off.comparator_off <=
        secondary_disable_seven[pmdb_pkg::S7_CMP1 +: 3];
      sec_off.gain_amp_off <=
        secondary_disable_seven[pmdb_pkg::S7_GAIN];
    end
  end

endmodule

`default_nettype wire

// >>> test/pmdb_bank_chk.sv
// checker: bus timing and field relations of the disable bank
`timescale 1ns/100ps
`default_nettype none
module pmdb_bank_chk (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [7:0]              paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [3:0]              pstrb,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire pmdb_pkg::pmdb_pri_off_s pri_off,
  input wire pmdb_pkg::pmdb_sec_off_s sec_off
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // write data as the lanes deliver it; a dead lane gives zeros
  wire logic [15:0] wd = pwdata[15:0] & {{8{pstrb[1]}}, {8{pstrb[0]}}};
  wire logic        wr = psel && penable && pready && pwrite;
  logic             unlock_q;
  // shadow of the unlock bit, kept from the bus alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) unlock_q <= 1'b0;
    else if (wr && paddr == 8'h08) unlock_q <= wd[11];
  end
  property p_answer; psel && !penable |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("setup not answered");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held too long");
  property p_upper; pready |-> prdata[31:16] == 16'h0000; endproperty
  a_upper: assert property (p_upper) else $error("upper half set");
  property p_unmapped; pready && paddr > 8'h1C |-> pslverr && prdata == 0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped accepted");
  property p_locked;
    wr && !unlock_q && paddr inside {8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C}
      |=> ##1 sec_off == $past(sec_off, 2);
  endproperty
  a_locked: assert property (p_locked) else $error("locked write landed");
  property p_pri7; wr && paddr == 8'h00 |=> ##1
    {pri_off.comparator1_off, pri_off.trigger_generator_off}
      == {$past(wd[8], 2), $past(wd[3], 2)};
  endproperty
  a_pri7: assert property (p_pri7) else $error("seven fields wrong");
  property p_cells; wr && paddr == 8'h04 |=> ##1
    pri_off.logic_cell_off == $past(wd[5:2], 2);
  endproperty
  a_cells: assert property (p_cells) else $error("cell fields wrong");
  property p_sec7; wr && unlock_q && paddr == 8'h1C |=> ##1
    {sec_off.comparator_off, sec_off.gain_amp_off}
      == {$past(wd[10:8], 2), $past(wd[1], 2)};
  endproperty
  a_sec7: assert property (p_sec7) else $error("comparator fields wrong");
  property p_rst; $rose(presetn) |-> pri_off == 0 && sec_off == 0; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared");
  c_open: cover property (wr && unlock_q && paddr == 8'h0C);
  c_shut: cover property (wr && !unlock_q && paddr == 8'h0C);
  c_err: cover property (pslverr);
endmodule
bind pmdb_bank pmdb_bank_chk u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
  .pri_off, .sec_off);
`default_nettype wire

// >>> test/pmdb_bank_tb_top.sv
// testbench: apb scenarios for the module-disable bank
`timescale 1ns/100ps
`default_nettype none
module pmdb_bank_tb_top;
  logic                    pclk;
  logic                    presetn;
  logic                    psel;
  logic                    penable;
  logic                    pwrite;
  logic [7:0]              paddr;
  logic [31:0]             pwdata;
  logic [3:0]              pstrb;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  pmdb_pkg::pmdb_pri_off_s pri_off;
  pmdb_pkg::pmdb_sec_off_s sec_off;
  logic [31:0]             rd;
  logic                    er;
  int                      bad_count;
  int                      compares;
  // lock register last, so a clearing pass ends locked
  logic [7:0]  adr [8] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C,
                           8'h08};
  logic [15:0] msk [8] = '{16'h0108, 16'h183E, 16'h0EA9, 16'h000F, 16'h0008,
                           16'h0300, 16'h0702, 16'h0800};
  // one set bit per entry: address, data, expected {pri_off, sec_off}
  logic [50:0] tbl [18] = '{
    {8'h00, 16'h0100, 27'h4000000}, {8'h00, 16'h0008, 27'h2000000},
    {8'h04, 16'h1000, 27'h1000000}, {8'h04, 16'h0800, 27'h0800000},
    {8'h04, 16'h0020, 27'h0400000}, {8'h04, 16'h0004, 27'h0080000},
    {8'h04, 16'h0002, 27'h0040000}, {8'h0C, 16'h0800, 27'h0020000},
    {8'h0C, 16'h0008, 27'h0001000}, {8'h0C, 16'h0001, 27'h0000800},
    {8'h10, 16'h0008, 27'h0000400}, {8'h10, 16'h0001, 27'h0000080},
    {8'h14, 16'h0008, 27'h0000040}, {8'h18, 16'h0200, 27'h0000020},
    {8'h18, 16'h0100, 27'h0000010}, {8'h1C, 16'h0400, 27'h0000008},
    {8'h1C, 16'h0100, 27'h0000002}, {8'h1C, 16'h0002, 27'h0000001}};

  pmdb_bank u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .pri_off, .sec_off);

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // one transfer; waits for ready, takes data at that edge only
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [15:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n == 16) bad_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 16'h0000, 4'hF);
    chk(rd, exp);
  endtask

  // outputs lag the register by one edge
  task automatic outs(input logic [31:0] exp);
    @(posedge pclk);
    #1;
    chk({5'h00, pri_off, sec_off}, exp);
  endtask

  task automatic t_reset_state;
    chk({5'h00, pri_off, sec_off}, 32'h0);
    for (int i = 0; i < 8; i++) rdc(adr[i], 32'h0);
  endtask

  task automatic t_locked;
    wr(8'h0C, 16'hFFFF);
    outs(32'h0);
    rdc(8'h0C, 32'h0);
  endtask

  task automatic t_masks;
    wr(8'h08, 16'h0800);
    for (int i = 0; i < 8; i++) wr(adr[i], 16'hFFFF);
    for (int i = 0; i < 8; i++) begin
      rdc(adr[i], {16'h0, msk[i]});
      chk({31'h0, er}, 32'h0);
    end
    outs(32'h07FFFFFF);
    for (int i = 0; i < 8; i++) wr(adr[i], 16'h0000);
  endtask

  task automatic t_fields;
    wr(8'h08, 16'h0800);
    foreach (tbl[i]) begin
      wr(tbl[i][50:43], tbl[i][42:27]);
      outs({5'h00, tbl[i][26:0]});
      wr(tbl[i][50:43], 16'h0000);
    end
  endtask

  // dead lane, unmapped place, relock, then reset in mid-run
  task automatic t_misc;
    apb(1'b1, 8'h04, 16'hFFFF, 4'h1);
    rdc(8'h04, 32'h003E);
    wr(8'h20, 16'hFFFF);
    chk({31'h0, er}, 32'h1);
    rdc(8'h20, 32'h0);
    chk({31'h0, er}, 32'h1);
    wr(8'h1C, 16'h0400);
    wr(8'h08, 16'h0000);
    wr(8'h1C, 16'h0000);
    rdc(8'h1C, 32'h0400);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_state;
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    bad_count = 0;
    compares = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_state;
    t_locked;
    t_masks;
    t_fields;
    t_misc;
    give_verdict;
  end

  // hang guard: the run needs well under 2000 cycles
  initial begin
    #100000;
    bad_count++;
    give_verdict;
  end
endmodule
`default_nettype wire
